// File: shared/adcct_map.svh
// constants of the converter control block: word size, clock rate, timing counts
// assumes a 10 MHz core clock; counts are derived from the printed times
`ifndef ADCCT_MAP_SVH
`define ADCCT_MAP_SVH

`define ADCCT_WORD_BITS 16
`define ADCCT_CLOCK_NS 100
`define ADCCT_CEIL_CYCLES(ns) (((ns) + `ADCCT_CLOCK_NS - 1) / `ADCCT_CLOCK_NS)
`define ADCCT_FLOOR_CYCLES(ns) (((ns) < `ADCCT_CLOCK_NS) ? 1 : ((ns) / `ADCCT_CLOCK_NS))

`define ADCCT_START_TO_BUSY_NS 35
`define ADCCT_CONV_NS 1250
`define ADCCT_CONV_CYCLES `ADCCT_FLOOR_CYCLES(`ADCCT_CONV_NS)
`define ADCCT_DATA_LEAD_NS 12
`define ADCCT_DATA_LEAD_CYCLES `ADCCT_CEIL_CYCLES(`ADCCT_DATA_LEAD_NS)
`define ADCCT_PUSH_AT (`ADCCT_CONV_CYCLES - 3 - `ADCCT_DATA_LEAD_CYCLES)
`define ADCCT_SYNC_DURING_NS 525
`define ADCCT_SYNC_DURING_CYCLES `ADCCT_FLOOR_CYCLES(`ADCCT_SYNC_DURING_NS)
`define ADCCT_SYNC_LOAD_AT (`ADCCT_SYNC_DURING_CYCLES - 2)

`define ADCCT_LEAD_FAST_NS 3
`define ADCCT_LEAD_SLOW_NS 17
`define ADCCT_PERIOD0_NS 25
`define ADCCT_PERIOD1_NS 50
`define ADCCT_PERIOD2_NS 100
`define ADCCT_PERIOD3_NS 200
`define ADCCT_TRAIL0_NS 3
`define ADCCT_TRAIL1_NS 55
`define ADCCT_TRAIL2_NS 130
`define ADCCT_TRAIL3_NS 290

`endif

// File: shared/adcct_pkg.sv
// types of the converter control block
// used by the core and the serializer
package adcct_pkg;

   typedef enum logic [1:0] {
      MODE_PARALLEL,
      MODE_MASTER_DURING,
      MODE_MASTER_AFTER,
      MODE_SLAVE
   } adcct_mode_type;

   typedef enum logic [2:0] {
      CS_IDLE,
      CS_CONVERT,
      CS_HANDOFF,
      CS_FINISH,
      CS_SERIAL
   } adcct_conv_state_type;

   typedef enum logic [2:0] {
      SS_IDLE,
      SS_LEAD,
      SS_SHIFT,
      SS_TRAIL,
      SS_SLAVE
   } adcct_ser_state_type;

endpackage

// File: logic/adcct_buffer.sv
// small result buffer with valid and ready on both sides
// assumes one clock; outData is read straight from the storage flops
`timescale 1ns/100ps
module adcct_buffer #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // filling side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // draining side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [CW-1:0] count_q, count_d;
   logic push, pop;

   assign inReady = (count_q != CW'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData = mem_q[rdPtr_q];

   always_comb begin
      push = inValid & inReady;
      pop = outValid & outReady;
      mem_d = mem_q;
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      if (push) begin
         mem_d[wrPtr_q] = inData;
         wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_q + 1'b1);
      end
      if (pop) begin
         rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_q + 1'b1);
      end
      count_d = CW'(count_q + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_q <= '{default: '0};
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         mem_q <= mem_d;
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end
endmodule

// File: logic/adcct_serializer.sv
// serial frame engine: master mode makes clock and frame, slave mode follows a host clock
// assumes the host clock input is already synchronous to the core clock
`timescale 1ns/100ps
`include "adcct_map.svh"
module adcct_serializer #(
   parameter int WIDTH = `ADCCT_WORD_BITS
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // word hand-in
   input wire logic load,
   input wire logic [WIDTH-1:0] word,
   input wire logic master,
   input wire logic [1:0] divSel,
   // host side
   input wire logic extClock,
   input wire logic fillBit,
   output logic serialClock,
   output logic serialData,
   output logic frame,
   // status
   output logic active,
   output logic done
);
   import adcct_pkg::*;

   localparam int BW = $clog2(WIDTH + 1);

   adcct_ser_state_type state_q, state_d;
   logic [WIDTH-1:0] shift_q, shift_d;
   logic [BW-1:0] bitCnt_q, bitCnt_d;
   logic [7:0] timer_q, timer_d;
   logic sclk_q, sclk_d, frame_q, frame_d, done_q, done_d, extPrev_q, extPrev_d;
   logic [7:0] halfCycles, leadCycles, trailCycles;

   // per-divider figures; the core clock bounds how fast the link can really toggle
   always_comb begin
      unique case (divSel)
         2'h0: begin
            halfCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_PERIOD0_NS / 2)); // RL7 RL10 RL11
            leadCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_LEAD_FAST_NS)); // RL13
            trailCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_TRAIL0_NS)); // RL14
         end
         2'h1: begin
            halfCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_PERIOD1_NS / 2)); // RL10 RL11
            leadCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_LEAD_SLOW_NS)); // RL13
            trailCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_TRAIL1_NS)); // RL14
         end
         2'h2: begin
            halfCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_PERIOD2_NS / 2)); // RL10 RL11
            leadCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_LEAD_SLOW_NS)); // RL13
            trailCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_TRAIL2_NS)); // RL14
         end
         default: begin
            halfCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_PERIOD3_NS / 2)); // RL10 RL11
            leadCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_LEAD_SLOW_NS)); // RL13
            trailCycles = 8'(`ADCCT_CEIL_CYCLES(`ADCCT_TRAIL3_NS)); // RL14
         end
      endcase
   end

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      bitCnt_d = bitCnt_q;
      timer_d = timer_q;
      sclk_d = sclk_q;
      frame_d = frame_q;
      done_d = 1'b0;
      extPrev_d = extClock;
      unique case (state_q)
         SS_IDLE: begin
            if (load) begin
               shift_d = word;
               bitCnt_d = '0;
               sclk_d = 1'b0;
               if (master) begin
                  frame_d = 1'b1;
                  timer_d = 8'(leadCycles - 8'h01);
                  state_d = SS_LEAD;
               end else begin
                  state_d = SS_SLAVE;
               end
            end
         end
         SS_LEAD: begin
            if (timer_q == '0) begin
               timer_d = 8'(halfCycles - 8'h01);
               state_d = SS_SHIFT;
            end else begin
               timer_d = 8'(timer_q - 8'h01);
            end
         end
         SS_SHIFT: begin
            if (timer_q != '0) begin
               timer_d = 8'(timer_q - 8'h01);
            end else begin
               timer_d = 8'(halfCycles - 8'h01);
               sclk_d = ~sclk_q;
               // data moves on the falling edge so the host samples on the rising one
               if (sclk_q) begin
                  bitCnt_d = BW'(bitCnt_q + 1'b1);
                  if (bitCnt_q == BW'(WIDTH - 1)) begin // RL19
                     timer_d = 8'(trailCycles - 8'h01);
                     state_d = SS_TRAIL;
                  end else begin
                     shift_d = {shift_q[WIDTH-2:0], fillBit};
                  end
               end
            end
         end
         SS_TRAIL: begin
            if (timer_q == '0) begin
               frame_d = 1'b0;
               done_d = 1'b1;
               state_d = SS_IDLE;
            end else begin
               timer_d = 8'(timer_q - 8'h01);
            end
         end
         SS_SLAVE: begin
            // falling host clock is the active edge; next bit one core cycle later
            if (extPrev_q && !extClock) begin // RL17
               bitCnt_d = BW'(bitCnt_q + 1'b1);
               shift_d = {shift_q[WIDTH-2:0], fillBit};
               if (bitCnt_q == BW'(WIDTH - 1)) begin // RL19
                  done_d = 1'b1;
                  state_d = SS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SS_IDLE;
         shift_q <= '0;
         bitCnt_q <= '0;
         timer_q <= '0;
         sclk_q <= 1'b0;
         frame_q <= 1'b0;
         done_q <= 1'b0;
         extPrev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         bitCnt_q <= bitCnt_d;
         timer_q <= timer_d;
         sclk_q <= sclk_d;
         frame_q <= frame_d;
         done_q <= done_d;
         extPrev_q <= extPrev_d;
      end
   end

   assign serialClock = sclk_q;
   assign serialData = shift_q[WIDTH-1];
   assign frame = frame_q;
   assign active = (state_q != SS_IDLE);
   assign done = done_q;
endmodule

// File: logic/adcct_core.sv
// converter control: conversion sequencing, busy, parallel and serial result read-out
// assumes all inputs synchronous to clock; the analog core offers its result on sampleResult
// Operation
// RL1 - busy rises at once on convert-start fall; the code keeps busy low and ignores the start while the buffer is full
// RL2 - busy high at most 1.25 us
// RL3 - parallel data valid within 1.25 us
// RL4 - data valid before busy falls
// RL5 - parallel data driven promptly on bus request
// RL6 - during-convert frame near 525 ns after start
// RL7 - during-convert serial clock fixed, fast period
// RL8 - after-convert frame when conversion completes
// RL9 - after-convert busy falls after frame ends
// RL10 - divider code selects minimum clock period
// RL11 - divider code bounds maximum clock period
// RL12 - after-convert busy time bounded per code
// RL13 - first clock edge waits after frame
// RL14 - frame held after last clock edge
// RL15 - serial outputs driven when chip select low
// RL16 - serial outputs released when chip select high
// RL17 - slave bit follows each host clock edge; the code moves a bit on the falling host clock edge only
// RL18 - result readable at conversion end, no latency
// RL19 - result delivered as one 16-bit word
// RL20 - host waits for busy before next step
`timescale 1ns/100ps
`include "adcct_map.svh"
module adcct_core #(
   parameter int WIDTH = `ADCCT_WORD_BITS,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // conversion control
   input wire logic convertStart_n,
   input wire adcct_pkg::adcct_mode_type interfaceMode,
   input wire logic [1:0] clockDividerSel,
   output logic busy,
   // analog core result
   input wire logic [WIDTH-1:0] sampleResult,
   // parallel port
   input wire logic chipSelect_n,
   input wire logic readRequest_n,
   output logic [WIDTH-1:0] parallelData,
   output logic parallelDataOe,
   // serial port
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   output logic serialClockOut,
   output logic serialClockOe,
   output logic frameSync,
   output logic frameSyncOe,
   output logic serialDataOut,
   output logic serialDataOe
);
   import adcct_pkg::*;

   adcct_conv_state_type state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic cnvPrev_q;
   logic [WIDTH-1:0] parData_q, parData_d;
   logic startFall, startOk;
   logic bufPush, bufInReady, bufOutValid, bufPop;
   logic [WIDTH-1:0] bufOutData;
   logic loadDuring, loadAfter, loadSlave, serLoad;
   logic serActive, serDone, serClock, serData, serFrame;
   logic isParallel, isMaster;

   assign isParallel = (interfaceMode == MODE_PARALLEL);
   assign isMaster = (interfaceMode == MODE_MASTER_DURING) || (interfaceMode == MODE_MASTER_AFTER);
   assign startFall = cnvPrev_q & ~convertStart_n;
   // a full buffer refuses the start, so no finished word is ever overwritten
   assign startOk = (state_q == CS_IDLE) & startFall & bufInReady;
   // busy is combinational so it rises in the same cycle the start is seen
   assign busy = (state_q != CS_IDLE) | startOk; // RL1 RL2 RL9

   always_comb begin
      loadDuring = (state_q == CS_CONVERT) && (interfaceMode == MODE_MASTER_DURING)
         && (cnt_q == 8'(`ADCCT_SYNC_LOAD_AT)) && bufOutValid && !serActive && !chipSelect_n; // RL6 RL7
      loadAfter = (state_q == CS_HANDOFF) && (interfaceMode == MODE_MASTER_AFTER)
         && bufOutValid && !serActive && !chipSelect_n; // RL8
      loadSlave = (interfaceMode == MODE_SLAVE) && bufOutValid && !serActive && !chipSelect_n; // RL18
      serLoad = loadDuring | loadAfter | loadSlave;
      bufPop = serLoad | (isParallel & bufOutValid);
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      parData_d = parData_q;
      bufPush = 1'b0;
      if (isParallel && bufOutValid) begin
         parData_d = bufOutData; // RL3 RL18 RL19
      end
      unique case (state_q)
         CS_IDLE: begin
            if (startOk) begin
               cnt_d = '0;
               state_d = CS_CONVERT;
            end
         end
         CS_CONVERT: begin
            cnt_d = 8'(cnt_q + 8'h01);
            if (cnt_q == 8'(`ADCCT_PUSH_AT)) begin
               bufPush = 1'b1; // RL18
               state_d = CS_HANDOFF;
            end
         end
         CS_HANDOFF: begin
            state_d = loadAfter ? CS_SERIAL : CS_FINISH;
         end
         CS_FINISH: begin
            // one cycle of margin between data valid and busy falling
            state_d = CS_IDLE; // RL4
         end
         CS_SERIAL: begin
            if (serDone) begin
               state_d = CS_IDLE; // RL9 RL12
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CS_IDLE;
         cnt_q <= '0;
         cnvPrev_q <= 1'b1;
         parData_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cnvPrev_q <= convertStart_n;
         parData_q <= parData_d;
      end
   end

   adcct_buffer #(
      .WIDTH(WIDTH),
      .DEPTH(BUF_DEPTH)
   ) resultBuffer (
      .clock(clock),
      .rst_n(rst_n),
      .inValid(bufPush),
      .inData(sampleResult),
      .inReady(bufInReady),
      .outValid(bufOutValid),
      .outData(bufOutData),
      .outReady(bufPop)
   );

   adcct_serializer #(
      .WIDTH(WIDTH)
   ) frameEngine (
      .clock(clock),
      .rst_n(rst_n),
      .load(serLoad),
      .word(bufOutData),
      .master(isMaster),
      // the during-convert mode ignores the divider and runs at the fastest rate
      .divSel((interfaceMode == MODE_MASTER_DURING) ? 2'h0 : clockDividerSel), // RL7 RL10
      .extClock(serialClockIn),
      .fillBit(serialDataIn),
      .serialClock(serClock),
      .serialData(serData),
      .frame(serFrame),
      .active(serActive),
      .done(serDone)
   );

   assign parallelData = parData_q;
   assign parallelDataOe = isParallel & ~chipSelect_n & ~readRequest_n; // RL5
   assign serialClockOut = serClock;
   assign frameSync = serFrame;
   assign serialDataOut = serData;
   assign serialClockOe = isMaster & ~chipSelect_n; // RL15 RL16
   assign frameSyncOe = isMaster & ~chipSelect_n; // RL15 RL16
   assign serialDataOe = ~isParallel & ~chipSelect_n; // RL15 RL16
endmodule

// File: testbench/adcct_core_asserts.sv
// checker of the converter control core, ports only
// assumes one clock domain; bound to every core instance
`timescale 1ns/100ps
module adcct_core_asserts #(
   parameter int WIDTH = 16,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // conversion
   input wire logic convertStart_n,
   input wire adcct_pkg::adcct_mode_type interfaceMode,
   input wire logic [1:0] clockDividerSel,
   input wire logic busy,
   input wire logic [WIDTH-1:0] sampleResult,
   // parallel port
   input wire logic chipSelect_n,
   input wire logic readRequest_n,
   input wire logic [WIDTH-1:0] parallelData,
   input wire logic parallelDataOe,
   // serial port
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   input wire logic serialClockOut,
   input wire logic serialClockOe,
   input wire logic frameSync,
   input wire logic frameSyncOe,
   input wire logic serialDataOut,
   input wire logic serialDataOe
);
   import adcct_pkg::*;
   logic [7:0] busyAge_q, busyAge_d, lowAge_q, lowAge_d;
   logic master;
   // ages count sampled cycles, so figures below are whole 100 ns steps
   assign master = interfaceMode == MODE_MASTER_DURING || interfaceMode == MODE_MASTER_AFTER;
   always_comb begin
      busyAge_d = busy ? busyAge_q + 8'h01 : 8'h00;
      lowAge_d = (frameSync && !serialClockOut) ? lowAge_q + 8'h01 : 8'h00;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busyAge_q <= 8'h00;
         lowAge_q <= 8'h00;
      end else begin
         busyAge_q <= busyAge_d;
         lowAge_q <= lowAge_d;
      end
   end
   function automatic int trail(input logic [1:0] sel);
      return (sel == 2'h3) ? 3 : (sel == 2'h2) ? 2 : 1;
   endfunction
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_rise;
      $fell(convertStart_n) && !$past(busy) && interfaceMode == MODE_PARALLEL |-> busy;
   endproperty
   a_rise: assert property (p_rise) else $error("busy missing after start");
   property p_width;
      busy && interfaceMode != MODE_MASTER_AFTER |-> busyAge_q < 8'h0C;
   endproperty
   a_width: assert property (p_width) else $error("busy too long");
   property p_lead;
      $changed(parallelData) |-> busy;
   endproperty
   a_lead: assert property (p_lead) else $error("data changed outside busy");
   property p_par_oe;
      parallelDataOe == (interfaceMode == MODE_PARALLEL && !chipSelect_n && !readRequest_n);
   endproperty
   a_par_oe: assert property (p_par_oe) else $error("parallel enable wrong");
   property p_ser_oe;
      serialDataOe == (interfaceMode != MODE_PARALLEL && !chipSelect_n);
   endproperty
   a_ser_oe: assert property (p_ser_oe) else $error("serial data enable wrong");
   property p_mst_oe;
      frameSyncOe == (master && !chipSelect_n) && serialClockOe == frameSyncOe;
   endproperty
   a_mst_oe: assert property (p_mst_oe) else $error("master enables wrong");
   property p_during;
      $rose(frameSync) && interfaceMode == MODE_MASTER_DURING |-> busyAge_q == 8'h05;
   endproperty
   a_during: assert property (p_during) else $error("during frame mistimed");
   property p_after;
      $rose(frameSync) && interfaceMode == MODE_MASTER_AFTER |-> busyAge_q == 8'h0B;
   endproperty
   a_after: assert property (p_after) else $error("after frame mistimed");
   property p_tail;
      $fell(frameSync) && interfaceMode == MODE_MASTER_AFTER |-> busy ##1 !busy;
   endproperty
   a_tail: assert property (p_tail) else $error("busy fall mistimed");
   property p_slow;
      busy && interfaceMode == MODE_MASTER_AFTER && clockDividerSel == 2'h3 |-> busyAge_q < 8'h39;
   endproperty
   a_slow: assert property (p_slow) else $error("busy too long, slow code");
   property p_first;
      $rose(frameSync) |-> !serialClockOut ##1 !serialClockOut ##1 serialClockOut;
   endproperty
   a_first: assert property (p_first) else $error("first edge mistimed");
   property p_half;
      $rose(serialClockOut) |=> $fell(serialClockOut);
   endproperty
   a_half: assert property (p_half) else $error("clock high too long");
   property p_hold;
      $fell(frameSync) |-> lowAge_q >= trail(interfaceMode == MODE_MASTER_AFTER ? clockDividerSel : 2'h0);
   endproperty
   a_hold: assert property (p_hold) else $error("frame dropped early");
   c_during: cover property ($rose(frameSync) && interfaceMode == MODE_MASTER_DURING);
   c_slow: cover property ($fell(frameSync) && clockDividerSel == 2'h3);
   c_par: cover property ($fell(busy) && interfaceMode == MODE_PARALLEL);
endmodule

bind adcct_core adcct_core_asserts #(.WIDTH(WIDTH), .BUF_DEPTH(BUF_DEPTH)) chk (
   .clock(clock), .rst_n(rst_n), .convertStart_n(convertStart_n), .interfaceMode(interfaceMode),
   .clockDividerSel(clockDividerSel), .busy(busy), .sampleResult(sampleResult), .chipSelect_n(chipSelect_n),
   .readRequest_n(readRequest_n), .parallelData(parallelData), .parallelDataOe(parallelDataOe),
   .serialClockIn(serialClockIn), .serialDataIn(serialDataIn), .serialClockOut(serialClockOut),
   .serialClockOe(serialClockOe), .frameSync(frameSync), .frameSyncOe(frameSyncOe),
   .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));

// File: testbench/adcct_host_model.sv
// host model: receives master frames, clocks slave reads
// assumes a released line shows the inverse of its last driven level
`timescale 1ns/100ps
module adcct_host_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // device serial pins
   input wire logic clockOut,
   input wire logic clockOe,
   input wire logic frameOut,
   input wire logic frameOe,
   input wire logic dataOut,
   input wire logic dataOe,
   // slave read
   input wire logic slaveGo,
   output logic hostClock,
   output logic hostBusy,
   // received word
   output logic [15:0] rxWord,
   output logic [7:0] rxBits
);
   logic [2:0] last_q;
   logic [7:0] phase_q, np;
   logic sclk, frame, data, sclkPrev_q, framePrev_q, take;
   assign sclk = clockOe ? clockOut : !last_q[2];
   assign frame = frameOe ? frameOut : !last_q[1];
   assign data = dataOe ? dataOut : !last_q[0];
   assign np = slaveGo ? 8'h61 : (phase_q != 8'h00 ? phase_q - 8'h01 : 8'h00);
   // slave clock: 2 cycles high, 4 low, still low between frames
   // master frames count only while the device drives frame and clock
   assign take = (frameOe && clockOe && frame && sclk && !sclkPrev_q) || (np != 8'h00 && (np - 8'h01) % 6 == 5);
   assign hostBusy = phase_q != 8'h00;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 3'h0;
         {sclkPrev_q, framePrev_q, hostClock} <= 3'h0;
         phase_q <= 8'h00;
         rxWord <= 16'h0000;
         rxBits <= 8'h00;
      end else begin
         // keep the last driven level, so a released line holds still at its inverse
         last_q <= {clockOe ? clockOut : last_q[2], frameOe ? frameOut : last_q[1], dataOe ? dataOut : last_q[0]};
         sclkPrev_q <= sclk;
         framePrev_q <= frame;
         phase_q <= np;
         hostClock <= np != 8'h00 && (np - 8'h01) % 6 >= 4;
         if ((frameOe && frame && !framePrev_q) || slaveGo) begin
            rxBits <= 8'h00;
         end else if (take) begin
            rxWord <= {rxWord[14:0], data};
            rxBits <= rxBits + 8'h01;
         end
      end
   end
endmodule

// File: testbench/adcct_core_tb.sv
// bench of the converter control core: parallel table, serial modes, buffer, reset
// assumes the checker and host model are compiled first
`timescale 1ns/100ps
module adcct_core_tb;
   import adcct_pkg::*;
   typedef struct {logic [15:0] value; logic [2:0] flags;} adcct_row_type;
   logic clock, rst_n, convertStart_n, chipSelect_n, readRequest_n, slaveGo;
   adcct_mode_type interfaceMode;
   logic [1:0] clockDividerSel;
   logic [15:0] sampleResult, parallelData, rxWord;
   logic [7:0] rxBits;
   logic busy, parallelDataOe, serialClockIn, serialClockOut, serialClockOe, frameSync, frameSyncOe;
   logic serialDataOut, serialDataOe, hostBusy;
   int miscompares, checked, n;
   // flags: chip select, read request, expected enable
   adcct_row_type rows [6] = '{'{16'h0000, 3'h1}, '{16'hFFFF, 3'h4}, '{16'h8001, 3'h2},
      '{16'h7FFE, 3'h6}, '{16'hA5C3, 3'h1}, '{16'h1234, 3'h1}};
   adcct_core dut (.clock(clock), .rst_n(rst_n), .convertStart_n(convertStart_n), .interfaceMode(interfaceMode),
      .clockDividerSel(clockDividerSel), .busy(busy), .sampleResult(sampleResult), .chipSelect_n(chipSelect_n),
      .readRequest_n(readRequest_n), .parallelData(parallelData), .parallelDataOe(parallelDataOe),
      .serialClockIn(serialClockIn), .serialDataIn(1'h0), .serialClockOut(serialClockOut),
      .serialClockOe(serialClockOe), .frameSync(frameSync), .frameSyncOe(frameSyncOe),
      .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
   adcct_host_model host (.clock(clock), .rst_n(rst_n), .clockOut(serialClockOut), .clockOe(serialClockOe),
      .frameOut(frameSync), .frameOe(frameSyncOe), .dataOut(serialDataOut), .dataOe(serialDataOe),
      .slaveGo(slaveGo), .hostClock(serialClockIn), .hostBusy(hostBusy), .rxWord(rxWord), .rxBits(rxBits));
   initial begin
      clock = 1'h0;
      forever #50 clock = !clock;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   // again: a second start in mid conversion, which must be ignored
   task automatic convert(input logic [15:0] value, input bit again, output int cnt);
      step(1);
      sampleResult = value;
      convertStart_n = 1'h0;
      cnt = 0;
      #1;
      while (busy === 1'h1 && cnt < 300) begin
         step(1);
         convertStart_n = !(again && cnt == 2);
         cnt++;
      end
      step(1);
      convertStart_n = 1'h1;
   endtask
   task automatic slave_read(input logic [15:0] exp);
      slaveGo = 1'h1;
      step(1);
      slaveGo = 1'h0;
      n = 0;
      while (hostBusy === 1'h1 && n < 200) begin
         step(1);
         n++;
      end
      step(3);
      check("slaveWord", rxWord, exp);
      check("slaveBits", rxBits, 16);
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #400000;
      miscompares++;
      end_of_test;
   end
   initial begin
      {convertStart_n, readRequest_n, chipSelect_n, slaveGo, rst_n} = 5'h18;
      {miscompares, checked} = 0;
      interfaceMode = MODE_PARALLEL;
      clockDividerSel = 2'h0;
      sampleResult = 16'h0000;
      step(5);
      rst_n = 1'h1;
      foreach (rows[i]) begin
         convert(rows[i].value, i == 3, n);
         check("busyCycles", n, 12);
         check("parallelData", parallelData, rows[i].value);
         {chipSelect_n, readRequest_n} = rows[i].flags[2:1];
         #1;
         check("parallelDataOe", parallelDataOe, rows[i].flags[0]);
      end
      rst_n = 1'h0;
      step(2);
      check("resetOutputs", {busy, frameSync, serialClockOut, serialDataOut, parallelData}, 20'h0);
      rst_n = 1'h1;
      interfaceMode = MODE_MASTER_AFTER;
      chipSelect_n = 1'h0;
      for (int c = 0; c < 4; c++) begin
         clockDividerSel = c[1:0];
         convert(16'hC35A + 16'(c), 1'b0, n);
         check("afterWord", rxWord, 16'hC35A + 16'(c));
         check("afterBits", rxBits, 16);
      end
      // chip select high keeps words buffered until the buffer refuses
      interfaceMode = MODE_MASTER_DURING;
      chipSelect_n = 1'h1;
      convert(16'h0F0F, 1'b0, n);
      convert(16'hF0F0, 1'b0, n);
      convert(16'h5555, 1'b0, n);
      check("fullRefuse", n, 0);
      interfaceMode = MODE_SLAVE;
      chipSelect_n = 1'h0;
      step(3);
      slave_read(16'h0F0F);
      slave_read(16'hF0F0);
      interfaceMode = MODE_MASTER_DURING;
      convert(16'h3C3C, 1'b0, n);
      convert(16'h9696, 1'b0, n);
      step(40);
      check("duringWord", rxWord, 16'h3C3C);
      check("duringBits", rxBits, 16);
      end_of_test;
   end
endmodule
